/* File: design/sss_pkg.sv */
// sss_pkg: constants, types and register map of the supply supervisor.
// assumes a 25 MHz system clock and an APB register port.
package sss_pkg;
   localparam int unsigned CLK_HZ           = 25_000_000;
   // startup delays in microseconds
   localparam int unsigned T_START_BROWN_US   = 3300;
   localparam int unsigned T_START_NOBROWN_US = 1000;
   localparam int unsigned START_BROWN_CYC    =
      (T_START_BROWN_US * (CLK_HZ / 1_000_000));
   localparam int unsigned START_NOBROWN_CYC  =
      (T_START_NOBROWN_US * (CLK_HZ / 1_000_000));
   // standby wake clock, kHz
   localparam int unsigned WAKE_OSC_KHZ     = 2100;
   localparam int unsigned BROWN_LEVELS     = 5;
   localparam int unsigned DET_LEVELS       = 7;
   localparam int unsigned DET_STEP_MV      = 200;

   // register byte offsets
   localparam logic [7:0] OFS_CTRL   = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_IEN    = 8'h08;
   localparam logic [7:0] OFS_ICLR   = 8'h0c;
   localparam logic [7:0] OFS_OPT    = 8'h10;

   // control fields
   localparam int unsigned CTL_DET_EN   = 0;
   localparam int unsigned CTL_LVL_LSB  = 1;
   localparam int unsigned CTL_REF_OFF  = 4;
   localparam int unsigned CTL_MODE_LSB = 5;
   localparam logic [31:0] CTRL_RST     = 32'h0000_0000;
   // status bits
   localparam int unsigned ST_FALL = 0;
   localparam int unsigned ST_RISE = 1;

   typedef enum logic [2:0] {
      PM_RUN      = 3'h0,
      PM_LP_RUN   = 3'h1,
      PM_SLEEP    = 3'h2,
      PM_LP_SLEEP = 3'h3,
      PM_STOP     = 3'h4,
      PM_STANDBY  = 3'h5
   } sss_pmode_e;

   typedef enum logic [1:0] {
      REG_MAIN = 2'h0,
      REG_LOWP = 2'h1,
      REG_OFF  = 2'h2
   } sss_reg_e;

   typedef enum logic [1:0] {
      BOOT_FLASH  = 2'h0,
      BOOT_SYSMEM = 2'h1,
      BOOT_RAM    = 2'h2
   } sss_boot_e;

   // option word as loaded: brownout disable and level
   typedef struct packed {
      logic       brown_dis;
      logic [2:0] brown_lvl;
   } sss_opt_s;

   // analog comparator inputs
   typedef struct packed {
      logic por_ok;
      logic brown_ok;
      logic det_above;
   } sss_ana_s;
endpackage : sss_pkg

/* File: design/sss_sync.sv */
// sss_sync: two-flop synchroniser for asynchronous levels.
// assumes one destination clock; first stage feeds only the second.
`timescale 1ns/1ps
module sss_sync #(
   parameter int unsigned W = 1
) (
   // clock and reset
   input  wire logic         ref_clk_i,
   input  wire logic         rst_n_i,
   // data
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);
   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= d_i;
         sync_q <= meta_q;
      end
   end

   assign q_o = sync_q;
endmodule : sss_sync

/* File: design/sss_supervisor.sv */
// sss_supervisor: reset/supply supervision sequencer with APB registers.
// assumes comparators, boot pins and option values are asynchronous.
//
// Operation
// - chip reset is held while the supply is below the power-down or brownout level.
// - option loading starts once the power-on level is crossed.
// - option load keeps, replaces or permanently disables brownout reset.
// - five brownout levels up to 3 V apply after option loading.
// - the supply detector has seven software levels about 200 mV apart.
// - interrupts are raised on falling, rising or both detector crossings.
// - the supply detector is idle until software enables it.
// - the internal reference may be switched off in Stop mode.
// - the regulator runs in main mode during Run mode.
// - the regulator is low power in low-power run, low-power sleep and Stop.
// - in Standby the regulator is off and only the standby domain keeps power.
// - boot pins sampled at startup choose flash, system memory or RAM.
// - system memory boot starts the loader over two serial ports or USB.
// - startup delay is 3.3 ms with brownout, 1 ms without.
// - Standby wakeup restarts on the multispeed oscillator at 2.1 MHz.
//
// Our own choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
module sss_supervisor #(
   parameter int unsigned START_BROWN_CYC   = sss_pkg::START_BROWN_CYC,
   parameter int unsigned START_NOBROWN_CYC = sss_pkg::START_NOBROWN_CYC
) (
   // clock and reset
   input  wire logic              ref_clk_i,
   input  wire logic              rst_n_i,
   // apb slave
   input  wire logic              psel_i,
   input  wire logic              penable_i,
   input  wire logic              pwrite_i,
   input  wire logic [7:0]        paddr_i,
   input  wire logic [31:0]       pwdata_i,
   output logic      [31:0]       prdata_o,
   output logic                   pready_o,
   output logic                   pslverr_o,
   // analog side and pins
   input  wire sss_pkg::sss_ana_s ana_i,
   input  wire logic [1:0]        boot_pins_i,
   input  wire sss_pkg::sss_opt_s opt_i,
   input  wire logic              brown_at_pwron_i,
   // core side
   input  wire logic              wake_standby_i,
   output logic                   chip_reset_n_o,
   output logic [2:0]             brown_sel_o,
   output logic                   brown_en_o,
   output logic [2:0]             det_level_o,
   output logic                   det_en_o,
   output logic                   ref_volt_en_o,
   output logic [1:0]             reg_mode_o,
   output logic                   core_pwr_en_o,
   output logic [1:0]             boot_src_o,
   output logic                   loader_run_o,
   output logic                   wake_osc_sel_o,
   output logic                   irq_o
);
   typedef enum logic [1:0] {
      ST_POR   = 2'h0,
      ST_LOAD  = 2'h1,
      ST_DELAY = 2'h2,
      ST_RUN   = 2'h3
   } sss_seq_e;

   // synchronised asynchronous inputs
   logic [9:0] raw_in;
   logic [9:0] syn;
   assign raw_in = {brown_at_pwron_i, opt_i, boot_pins_i, ana_i};
   sss_sync #(.W(10)) u_sync (
      .ref_clk_i (ref_clk_i),
      .rst_n_i   (rst_n_i),
      .d_i       (raw_in),
      .q_o       (syn)
   );
   wire       por_ok      = syn[2];
   wire       brown_ok    = syn[1];
   wire       det_above   = syn[0];
   wire [1:0] boot_pins   = syn[4:3];
   wire [3:0] opt_word    = syn[8:5];
   wire       brown_pwron = syn[9];

   sss_seq_e    seq_q, seq_d;
   logic [16:0] cnt_q, cnt_d;
   logic        brown_en_q;
   logic [2:0]  brown_sel_q;
   logic [1:0]  boot_q;
   logic [31:0] ctrl_q;
   logic [1:0]  stat_q;
   logic [1:0]  ien_q;
   logic        det_prev_q;
   logic        wake_q;

   // sequencer
   wire supply_bad = !por_ok || (brown_en_q && !brown_ok);
   wire [16:0] dly_cyc = brown_pwron ? 17'(START_BROWN_CYC)
                                     : 17'(START_NOBROWN_CYC);
   always_comb begin
      seq_d = seq_q;
      cnt_d = cnt_q;
      case (seq_q)
         ST_POR: if (por_ok) begin
            seq_d = ST_LOAD;
         end
         ST_LOAD: begin
            seq_d = ST_DELAY;
            cnt_d = dly_cyc;
         end
         ST_DELAY: if (cnt_q <= 17'h1) begin
            seq_d = ST_RUN;
         end else begin
            cnt_d = cnt_q - 17'h1;
         end
         ST_RUN: ;
         default: seq_d = ST_POR;
      endcase
      if (supply_bad) begin
         seq_d = ST_POR;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         seq_q     <= ST_POR;
         cnt_q     <= 17'h0;
         brown_en_q  <= 1'b0;
         brown_sel_q <= 3'h0;
         boot_q      <= 2'h0;
      end else begin
         seq_q <= seq_d;
         cnt_q <= cnt_d;
         if (seq_q == ST_POR) begin
            brown_en_q <= brown_pwron;
         end
         if (seq_q == ST_LOAD) begin
            brown_en_q  <= brown_pwron && !opt_word[3];
            brown_sel_q <= (opt_word[2:0] < 3'(sss_pkg::BROWN_LEVELS))
                           ? opt_word[2:0] : 3'h0;
            boot_q      <= boot_pins;
         end
      end
   end

   // apb registers
   wire acc   = psel_i && penable_i;
   wire wr    = acc && pwrite_i;
   wire hit_c = paddr_i == sss_pkg::OFS_CTRL;
   wire hit_s = paddr_i == sss_pkg::OFS_STATUS;
   wire hit_e = paddr_i == sss_pkg::OFS_IEN;
   wire hit_k = paddr_i == sss_pkg::OFS_ICLR;
   wire hit_o = paddr_i == sss_pkg::OFS_OPT;
   wire mapped = hit_c || hit_s || hit_e || hit_k || hit_o;

   // detector edges, only while enabled
   wire det_en   = ctrl_q[sss_pkg::CTL_DET_EN];
   wire ev_rise  = det_en && det_above && !det_prev_q;
   wire ev_fall  = det_en && !det_above && det_prev_q;
   wire [1:0] clr = (wr && hit_k) ? pwdata_i[1:0] : 2'h0;
   wire [2:0] lvl_w = pwdata_i[sss_pkg::CTL_LVL_LSB +: 3];

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         ctrl_q     <= sss_pkg::CTRL_RST;
         stat_q     <= 2'h0;
         ien_q      <= 2'h0;
         det_prev_q <= 1'b0;
      end else begin
         det_prev_q <= det_above;
         if (wr && hit_c) begin
            ctrl_q <= {24'h0, pwdata_i[7:4],
                       (lvl_w < 3'(sss_pkg::DET_LEVELS)) ? lvl_w
                       : ctrl_q[3:1], pwdata_i[0]};
         end
         if (wr && hit_e) begin
            ien_q <= pwdata_i[1:0];
         end
         // set wins over clear
         stat_q[sss_pkg::ST_FALL] <= ev_fall
            || (stat_q[sss_pkg::ST_FALL] && !clr[0]);
         stat_q[sss_pkg::ST_RISE] <= ev_rise
            || (stat_q[sss_pkg::ST_RISE] && !clr[1]);
      end
   end

   assign irq_o = |(stat_q & ien_q);

   always_comb begin
      prdata_o = 32'h0;
      if (hit_c) prdata_o = ctrl_q;
      if (hit_s) prdata_o = {30'h0, stat_q};
      if (hit_e) prdata_o = {30'h0, ien_q};
      if (hit_o) prdata_o = {24'h0, seq_q, boot_q, brown_en_q, brown_sel_q};
   end
   assign pready_o  = 1'b1;
   assign pslverr_o = acc && !mapped;

   // power mode mapping
   wire [2:0] pmode = ctrl_q[sss_pkg::CTL_MODE_LSB +: 3];
   always_comb begin
      case (pmode)
         sss_pkg::PM_RUN,
         sss_pkg::PM_SLEEP:    reg_mode_o = sss_pkg::REG_MAIN;
         sss_pkg::PM_LP_RUN,
         sss_pkg::PM_LP_SLEEP,
         sss_pkg::PM_STOP:     reg_mode_o = sss_pkg::REG_LOWP;
         sss_pkg::PM_STANDBY:  reg_mode_o = sss_pkg::REG_OFF;
         default:              reg_mode_o = sss_pkg::REG_MAIN;
      endcase
   end
   assign core_pwr_en_o = pmode != sss_pkg::PM_STANDBY;
   assign ref_volt_en_o = !(pmode == sss_pkg::PM_STOP
                            && ctrl_q[sss_pkg::CTL_REF_OFF]);

   // standby wake selects the multispeed oscillator
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         wake_q <= 1'b0;
      end else if (wake_standby_i) begin
         wake_q <= 1'b1;
      end else if (seq_q == ST_RUN && pmode != sss_pkg::PM_STANDBY) begin
         wake_q <= 1'b0;
      end
   end

   assign chip_reset_n_o = seq_q == ST_RUN;
   assign brown_en_o     = brown_en_q;
   assign brown_sel_o    = brown_sel_q;
   assign det_en_o       = det_en;
   assign det_level_o    = ctrl_q[3:1];
   assign boot_src_o     = boot_q;
   assign loader_run_o   = chip_reset_n_o
                           && boot_q == sss_pkg::BOOT_SYSMEM;
   assign wake_osc_sel_o = wake_q;

   // checks
   rst_holds_a: assert property (@(posedge ref_clk_i)
      disable iff (!rst_n_i) supply_bad |=> !chip_reset_n_o)
      else $error("reset not held on bad supply");
   load_after_por_a: assert property (@(posedge ref_clk_i)
      disable iff (!rst_n_i)
      (seq_q == ST_POR && por_ok && !supply_bad) |=> seq_q == ST_LOAD)
      else $error("option load did not start");
   brown_off_a: assert property (@(posedge ref_clk_i)
      disable iff (!rst_n_i)
      (seq_q == ST_LOAD && opt_word[3]) |=> !brown_en_q)
      else $error("brownout not disabled");
   brown_range_a: assert property (@(posedge ref_clk_i)
      disable iff (!rst_n_i) brown_sel_q < 3'(sss_pkg::BROWN_LEVELS))
      else $error("brownout level out of range");
   brown_lvl_a: assert property (@(posedge ref_clk_i)
      disable iff (!rst_n_i)
      (seq_q == ST_LOAD && opt_word[2:0] < 3'(sss_pkg::BROWN_LEVELS))
      |=> brown_sel_q == $past(opt_word[2:0]))
      else $error("brownout level not applied");
   det_level_a: assert property (@(posedge ref_clk_i)
      disable iff (!rst_n_i) det_level_o < 3'(sss_pkg::DET_LEVELS))
      else $error("detector level out of range");
   irq_flag_a: assert property (@(posedge ref_clk_i)
      disable iff (!rst_n_i)
      (ev_fall && ien_q[0] && !(wr && hit_e)) |=> irq_o)
      else $error("interrupt missing after fall");
   rise_irq_a: assert property (@(posedge ref_clk_i)
      disable iff (!rst_n_i)
      (ev_rise && ien_q[1] && !(wr && hit_e)) |=> irq_o)
      else $error("interrupt missing after rise");
   det_idle_a: assert property (@(posedge ref_clk_i)
      disable iff (!rst_n_i)
      (!det_en && stat_q == 2'h0) |=> stat_q == 2'h0)
      else $error("flag set while detector off");
   ref_off_a: assert property (@(posedge ref_clk_i)
      disable iff (!rst_n_i)
      (pmode == sss_pkg::PM_STOP && ctrl_q[sss_pkg::CTL_REF_OFF])
      |-> !ref_volt_en_o)
      else $error("reference left on in stop");
   ref_on_a: assert property (@(posedge ref_clk_i)
      disable iff (!rst_n_i) pmode != sss_pkg::PM_STOP |-> ref_volt_en_o)
      else $error("reference off outside stop");
   main_in_run_a: assert property (@(posedge ref_clk_i)
      disable iff (!rst_n_i)
      pmode == sss_pkg::PM_RUN |-> reg_mode_o == sss_pkg::REG_MAIN)
      else $error("regulator not main in run");
   reg_lowp_a: assert property (@(posedge ref_clk_i)
      disable iff (!rst_n_i)
      (pmode == sss_pkg::PM_STOP || pmode == sss_pkg::PM_LP_RUN
       || pmode == sss_pkg::PM_LP_SLEEP)
      |-> reg_mode_o == sss_pkg::REG_LOWP)
      else $error("regulator not low power");
   standby_off_a: assert property (@(posedge ref_clk_i)
      disable iff (!rst_n_i)
      pmode == sss_pkg::PM_STANDBY
      |-> (reg_mode_o == sss_pkg::REG_OFF && !core_pwr_en_o))
      else $error("core left powered in standby");
   boot_latch_a: assert property (@(posedge ref_clk_i)
      disable iff (!rst_n_i) seq_q == ST_LOAD |=> boot_q == $past(boot_pins))
      else $error("boot pins not latched");
   loader_run_a: assert property (@(posedge ref_clk_i)
      disable iff (!rst_n_i)
      (chip_reset_n_o && boot_q == sss_pkg::BOOT_SYSMEM) |-> loader_run_o)
      else $error("loader not started");
   delay_load_a: assert property (@(posedge ref_clk_i)
      disable iff (!rst_n_i)
      (seq_q == ST_LOAD && !supply_bad)
      |=> (seq_q == ST_DELAY && cnt_q == $past(dly_cyc)))
      else $error("startup delay not loaded");
   delay_len_a: assert property (@(posedge ref_clk_i)
      disable iff (!rst_n_i)
      (seq_q == ST_DELAY && cnt_q > 17'h1 && !supply_bad)
      |=> seq_q == ST_DELAY)
      else $error("startup delay cut short");
   wake_osc_a: assert property (@(posedge ref_clk_i)
      disable iff (!rst_n_i) wake_standby_i |=> wake_osc_sel_o)
      else $error("wake oscillator not selected");
   fall_flag_a: assert property (@(posedge ref_clk_i)
      disable iff (!rst_n_i)
      ($fell(det_above) && det_en) |=> stat_q[sss_pkg::ST_FALL])
      else $error("fall flag not set");
   rise_flag_a: assert property (@(posedge ref_clk_i)
      disable iff (!rst_n_i)
      ($rose(det_above) && det_en) |=> stat_q[sss_pkg::ST_RISE])
      else $error("rise flag not set");
endmodule : sss_supervisor

/* File: tb/sss_ana_model.sv */
// sss_ana_model: behavioural supply comparators facing the supervisor.
// assumes the bench gives the supply in millivolts; levels are async.
`timescale 1ns/1ps
module sss_ana_model (
   // supply and selected levels
   input  wire logic [15:0]      supply_mv_i,
   input  wire logic             pwron_hi_i,
   input  wire logic [2:0]       drop_sel_i,
   input  wire logic [2:0]       det_level_i,
   // comparator levels
   output sss_pkg::sss_ana_s     ana_o
);
   logic [15:0] on_mv;
   // power-on level 1.8 V or 1.65 V
   assign on_mv = pwron_hi_i ? 16'h708 : 16'h672;
   assign ana_o.por_ok = supply_mv_i >= on_mv;
   // five levels 1.8 V to 3 V
   assign ana_o.brown_ok =
      supply_mv_i >= 16'h708 + 16'h12c * drop_sel_i;
   // seven levels from 1.85 V in 200 mV steps
   assign ana_o.det_above =
      supply_mv_i >= 16'h73a + 16'hc8 * det_level_i;
endmodule : sss_ana_model

/* File: tb/tb_top.sv */
// tb_top: self-checking bench of the supply supervisor.
// assumes short startup counts and the comparator model.
`timescale 1ns/1ps
module tb_top;
   localparam int NB = 10;
   localparam int NN = 5;
   logic clk, rst_n, psel, pen, pwr, pready, perr, er, wake, bpwr;
   logic rst_o, ben, den, refen, cpwr, ldr, wosc, irq;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [1:0]  boot, rmode, bsrc;
   logic [2:0]  bsel, dlvl;
   logic [15:0] mv;
   sss_pkg::sss_ana_s ana;
   sss_pkg::sss_opt_s opt;
   int fails, checks_done;

   sss_supervisor #(.START_BROWN_CYC(NB), .START_NOBROWN_CYC(NN)) dut_u (
      .ref_clk_i(clk), .rst_n_i(rst_n), .psel_i(psel), .penable_i(pen),
      .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata),
      .prdata_o(prdata), .pready_o(pready), .pslverr_o(perr),
      .ana_i(ana), .boot_pins_i(boot), .opt_i(opt),
      .brown_at_pwron_i(bpwr), .wake_standby_i(wake),
      .chip_reset_n_o(rst_o), .brown_sel_o(bsel), .brown_en_o(ben),
      .det_level_o(dlvl), .det_en_o(den), .ref_volt_en_o(refen),
      .reg_mode_o(rmode), .core_pwr_en_o(cpwr), .boot_src_o(bsrc),
      .loader_run_o(ldr), .wake_osc_sel_o(wosc), .irq_o(irq));

   sss_ana_model model_u (
      .supply_mv_i(mv), .pwron_hi_i(bpwr), .drop_sel_i(bsel),
      .det_level_i(dlvl), .ana_o(ana));

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   task automatic summarize;
      if (fails == 0 && checks_done > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : summarize

   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                      input string m);
      checks_done++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask : chk

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : cyc

   // one apb transfer, then one idle edge so results settle
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      chk(pready, 1'b1, "apb ready");
      rd = prdata;
      er = perr;
      psel <= 1'b0;
      pen <= 1'b0;
      @(posedge clk);
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr

   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rd, e, "read");
   endtask : rdc

   task automatic boot_up(input logic bp, input logic [1:0] bt,
                          input sss_pkg::sss_opt_s o, input int n);
      int c;
      mv <= 16'h0;
      cyc(4);
      bpwr <= bp;
      boot <= bt;
      opt <= o;
      mv <= 16'hce4;
      c = 0;
      do begin
         @(posedge clk);
         c++;
      end while (rst_o !== 1'b1 && c < n + 40);
      chk(c >= n && c <= n + 8, 1'b1, "startup delay");
   endtask : boot_up

   task automatic t_reset;
      chk(rst_o, 1'b0, "held");
      chk(rmode, sss_pkg::REG_MAIN, "reg mode");
      chk(den, 1'b0, "det off");
      rdc(sss_pkg::OFS_CTRL, sss_pkg::CTRL_RST);
      rdc(sss_pkg::OFS_STATUS, 32'h0);
      rdc(8'h14, 32'h0);
      chk(er, 1'b1, "unmapped");
   endtask : t_reset

   task automatic t_power;
      boot_up(1'b1, 2'h1, 4'h3, NB);
      chk({ben, bsel}, 4'hb, "drop level");
      chk({bsrc, ldr}, {sss_pkg::BOOT_SYSMEM, 1'b1}, "boot");
      rdc(sss_pkg::OFS_OPT, 32'hdb);
      mv <= 16'ha28;
      cyc(5);
      chk(rst_o, 1'b0, "drop reset");
      boot_up(1'b0, 2'h2, 4'he, NN);
      chk({ben, bsel}, 4'h0, "drop off");
      chk({bsrc, ldr}, {sss_pkg::BOOT_RAM, 1'b0}, "boot");
      mv <= 16'h6a4;
      cyc(5);
      chk(rst_o, 1'b1, "no drop reset");
      mv <= 16'h640;
      cyc(5);
      chk(rst_o, 1'b0, "low reset");
      boot_up(1'b0, 2'h0, 4'he, NN);
      chk(bsrc, sss_pkg::BOOT_FLASH, "boot");
   endtask : t_power

   task automatic dip;
      mv <= 16'h7d0;
      cyc(6);
   endtask : dip

   task automatic t_det;
      wr(sss_pkg::OFS_CTRL, 32'h4);
      wr(sss_pkg::OFS_IEN, 32'h3);
      dip();
      mv <= 16'hce4;
      cyc(6);
      rdc(sss_pkg::OFS_STATUS, 32'h0);
      wr(sss_pkg::OFS_CTRL, 32'h5);
      wr(sss_pkg::OFS_CTRL, 32'hf);
      chk({den, dlvl}, 4'ha, "level");
      wr(sss_pkg::OFS_IEN, 32'h1);
      dip();
      rdc(sss_pkg::OFS_STATUS, 32'h1);
      chk(irq, 1'b1, "irq fall");
      mv <= 16'hce4;
      cyc(6);
      rdc(sss_pkg::OFS_STATUS, 32'h3);
      wr(sss_pkg::OFS_ICLR, 32'h1);
      chk(irq, 1'b0, "irq masked");
      wr(sss_pkg::OFS_IEN, 32'h2);
      chk(irq, 1'b1, "irq rise");
      wr(sss_pkg::OFS_ICLR, 32'h3);
      chk(irq, 1'b0, "irq clear");
      rdc(sss_pkg::OFS_STATUS, 32'h0);
   endtask : t_det

   task automatic t_modes;
      logic [1:0] e;
      for (int m = 0; m < 6; m++) begin
         e = (m == 0 || m == 2) ? sss_pkg::REG_MAIN :
             (m == 5) ? sss_pkg::REG_OFF : sss_pkg::REG_LOWP;
         wr(sss_pkg::OFS_CTRL, (m << 5) | 32'h10);
         chk(rmode, e, "reg mode");
         chk(cpwr, m != 5, "core power");
         chk(refen, m != 4, "ref off");
      end
      wr(sss_pkg::OFS_CTRL, 32'h80);
      chk(refen, 1'b1, "ref kept");
      wr(sss_pkg::OFS_CTRL, 32'ha0);
      wake <= 1'b1;
      cyc(1);
      wake <= 1'b0;
      cyc(2);
      chk(wosc, 1'b1, "wake osc");
      wr(sss_pkg::OFS_CTRL, 32'h0);
      cyc(1);
      chk(wosc, 1'b0, "run osc");
   endtask : t_modes

   initial begin
      rst_n = 1'b0;
      {psel, pen, pwr, wake, bpwr} = 5'h0;
      paddr = 8'h0;
      pwdata = 32'h0;
      boot = 2'h0;
      opt = 4'h0;
      mv = 16'h0;
      fails = 0;
      checks_done = 0;
      cyc(3);
      rst_n <= 1'b1;
      cyc(1);
      t_reset();
      t_power();
      t_det();
      t_modes();
      summarize();
   end

   initial begin
      cyc(20000);
      fails++;
      summarize();
   end
endmodule : tb_top
